// *** hw/umb_pkg.sv ***
/*
 * Shared constants and types of the serial port: register offsets, field positions, reset values, divider counts,
 * state encodings and the register request carrier.
 * Assumes a single core clock domain; MC_LAST, M0_HIGH and M2_LAST count core clock cycles, the other counts ticks or bits.
 */
package umb_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [2:0] ADDR_CTRL  = 3'h0;
	localparam logic [2:0] ADDR_DATA  = 3'h1;
	localparam logic [2:0] ADDR_PWR   = 3'h2;
	localparam logic [2:0] ADDR_T1RL  = 3'h3;
	localparam logic [2:0] ADDR_T2CTL = 3'h4;
	localparam logic [2:0] ADDR_T2RH  = 3'h5;
	localparam logic [2:0] ADDR_T2RL  = 3'h6;
	localparam logic [2:0] ADDR_FRAC  = 3'h7;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTL_MODE_HI = 7;
	localparam int CTL_MODE_LO = 6;
	localparam int CTL_MP      = 5;
	localparam int CTL_REN     = 4;
	localparam int CTL_TB8     = 3;
	localparam int CTL_RB8     = 2;
	localparam int CTL_TI      = 1;
	localparam int CTL_RI      = 0;
	localparam int PWR_DOUBLE  = 7;
	localparam int T2_RCLK     = 5;
	localparam int T2_TIMER2_TX_CLOCK_SELECT     = 4;
	localparam int FRAC_EN     = 7;

	// ----------------------------------------------------------------
	// reset values and timing counts
	// ----------------------------------------------------------------
	localparam logic [7:0]  RST_REG    = 8'h00;
	localparam logic [3:0]  MC_LAST    = 4'hb;
	localparam logic [3:0]  M0_HIGH    = 4'h6;
	localparam logic [1:0]  M2_LAST    = 2'h3;
	localparam logic [3:0]  RX_MID     = 4'h7;
	localparam logic [3:0]  SUB_LAST   = 4'hf;
	localparam logic [3:0]  BITS8_LAST = 4'h7;
	localparam logic [3:0]  MODE1_LAST = 4'h8;
	localparam logic [3:0]  MODE9_LAST = 4'h9;
	localparam logic [7:0]  T1_FULL    = 8'hff;
	localparam logic [15:0] T2_FULL    = 16'hffff;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001,
		TX_SEND = 4'b0010,
		TX_STOP = 4'b0100,
		TX_SH0  = 4'b1000
	} umb_tx_e;

	typedef enum logic [3:0] {
		RX_IDLE  = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA  = 4'b0100,
		RX_SH0   = 4'b1000
	} umb_rx_e;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} umb_req_s;

endpackage

// *** hw/umb_uart.sv ***
/*
 * Four-mode serial port with baud source selection: shift register mode, 8-bit and 9-bit asynchronous
 * modes, machine-cycle timer, two-cycle timer with 16-bit reload, and an external fractional tick.
 * Assumes one core clock, an asynchronous active-low reset, and a register master that never needs waits.
 */
`timescale 1ns/10ps

// Contract
// - mode 00 shifts eight bits LSB first
// - shift receive starts when enabled and flag clear
// - shift clock is core clock over twelve
// - mode 01 frame: start, eight data, stop
// - data write loads one as ninth bit
// - 8-bit receive starts on falling edge
// - accept needs clear flag and multiprocessor check
// - rejected frame is dropped, flag stays clear
// - mode 10 frame carries programmable ninth bit
// - fixed rate is core over 64 or 32
// - 9-bit send starts on next divide-by-16 baud tick rollover
// - 9-bit receive stores ninth bit, sets flag
// - mode 11 is 9-bit at variable rate
// - only a data buffer write starts sending
// - async receive needs enable and start bit
// - timer one rate with double bit over 32
// - timer two selects route each direction separately
// - timer two counts every two cycles, sixteen per bit
// - multiprocessor mode drops frames with ninth bit zero
// - fractional enable overrides double and timer-two selects except in mode 10
module umb_uart (
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  umb_pkg::umb_req_s     req_i,
	output logic [7:0]            rd_data_o,
	input  wire logic             rxd_i,
	input  wire logic             frac_tick_i,
	output logic                  rxd_o,
	output logic                  rxd_oe_o,
	output logic                  txd_o
);
	import umb_pkg::*;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0]  ctrl_r;
	logic [7:0]  tx_data_r;
	logic [7:0]  rx_buf_r;
	logic        dbl_r;
	logic [7:0]  t1_reload_r;
	logic        timer2_tx_clock_select_sel_r;
	logic        rclk_sel_r;
	logic [15:0] t2_reload_r;
	logic        frac_en_r;

	logic        wr_data;
	logic        mode0;
	logic        mode2;
	logic        nine;
	logic        ti_set;
	logic        rx_accept;
	logic        rx_async_end;
	logic        rx_s_r;

	assign wr_data = req_i.wr && (req_i.addr == ADDR_DATA);
	assign mode0   = !ctrl_r[CTL_MODE_HI] && !ctrl_r[CTL_MODE_LO];
	assign mode2   = ctrl_r[CTL_MODE_HI] && !ctrl_r[CTL_MODE_LO];
	assign nine    = ctrl_r[CTL_MODE_HI];

	// hardware sets win over a software write in the same cycle
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl_r <= RST_REG;
		end else begin
			if (req_i.wr && req_i.addr == ADDR_CTRL) begin
				ctrl_r <= req_i.wdata;
			end
			if (ti_set) begin
				ctrl_r[CTL_TI] <= 1'b1;
			end
			if (rx_accept) begin
				ctrl_r[CTL_RI] <= 1'b1;
			end
			if (rx_accept && rx_async_end) begin
				ctrl_r[CTL_RB8] <= rx_s_r;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_data_r   <= RST_REG;
			dbl_r       <= 1'b0;
			t1_reload_r <= RST_REG;
			timer2_tx_clock_select_sel_r  <= 1'b0;
			rclk_sel_r  <= 1'b0;
			t2_reload_r <= {RST_REG, RST_REG};
			frac_en_r   <= 1'b0;
		end else if (req_i.wr) begin
			case (req_i.addr)
				ADDR_DATA: begin
					tx_data_r <= req_i.wdata;
				end
				ADDR_PWR: begin
					dbl_r <= req_i.wdata[PWR_DOUBLE];
				end
				ADDR_T1RL: begin
					t1_reload_r <= req_i.wdata;
				end
				ADDR_T2CTL: begin
					timer2_tx_clock_select_sel_r <= req_i.wdata[T2_TIMER2_TX_CLOCK_SELECT];
					rclk_sel_r <= req_i.wdata[T2_RCLK];
				end
				ADDR_T2RH: begin
					t2_reload_r[15:8] <= req_i.wdata;
				end
				ADDR_T2RL: begin
					t2_reload_r[7:0] <= req_i.wdata;
				end
				ADDR_FRAC: begin
					frac_en_r <= req_i.wdata[FRAC_EN];
				end
				default: begin
				end
			endcase
		end
	end

	// read data stand for one cycle only
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_data_o <= RST_REG;
		end else if (!req_i.rd) begin
			rd_data_o <= RST_REG;
		end else begin
			case (req_i.addr)
				ADDR_CTRL:  rd_data_o <= ctrl_r;
				ADDR_DATA:  rd_data_o <= rx_buf_r;
				ADDR_PWR:   rd_data_o <= {dbl_r, 7'h00};
				ADDR_T1RL:  rd_data_o <= t1_reload_r;
				ADDR_T2CTL: rd_data_o <= {2'h0, rclk_sel_r, timer2_tx_clock_select_sel_r, 4'h0};
				ADDR_T2RH:  rd_data_o <= t2_reload_r[15:8];
				ADDR_T2RL:  rd_data_o <= t2_reload_r[7:0];
				default:    rd_data_o <= {frac_en_r, 7'h00};
			endcase
		end
	end

	// ----------------------------------------------------------------
	// baud sources
	// ----------------------------------------------------------------
	logic [3:0]  m_cnt_r;
	logic [7:0]  t1_cnt_r;
	logic        t1_half_r;
	logic        t2_ph_r;
	logic [15:0] t2_cnt_r;
	logic [1:0]  m2_cnt_r;
	logic        mc_tick;
	logic        t1_ovf;
	logic        t1_tick;
	logic        t2_run;
	logic        t2_ovf;
	logic        m2_tick;
	logic        tx_tick;
	logic        rx_tick;

	assign mc_tick = (m_cnt_r == MC_LAST);
	assign t1_ovf  = mc_tick && (t1_cnt_r == T1_FULL);
	assign t1_tick = t1_ovf && (dbl_r || t1_half_r);
	assign t2_run  = timer2_tx_clock_select_sel_r || rclk_sel_r;
	assign t2_ovf  = t2_run && t2_ph_r && (t2_cnt_r == T2_FULL);
	assign m2_tick = dbl_r ? m2_cnt_r[0] : (m2_cnt_r == M2_LAST);
	// fractional source ignores double bit and timer-two selects
	assign tx_tick = mode2 ? m2_tick : (frac_en_r ? frac_tick_i : (timer2_tx_clock_select_sel_r ? t2_ovf : t1_tick));
	assign rx_tick = mode2 ? m2_tick : (frac_en_r ? frac_tick_i : (rclk_sel_r ? t2_ovf : t1_tick));

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			m_cnt_r  <= 4'h0;
			m2_cnt_r <= 2'h0;
		end else begin
			m_cnt_r  <= mc_tick ? 4'h0 : m_cnt_r + 4'h1;
			m2_cnt_r <= m2_cnt_r + 2'h1;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			t1_cnt_r  <= RST_REG;
			t1_half_r <= 1'b0;
		end else if (mc_tick) begin
			t1_cnt_r  <= t1_ovf ? t1_reload_r : t1_cnt_r + 8'h01;
			t1_half_r <= t1_half_r ^ t1_ovf;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			t2_ph_r  <= 1'b0;
			t2_cnt_r <= {RST_REG, RST_REG};
		end else if (t2_run) begin
			t2_ph_r <= !t2_ph_r;
			if (t2_ph_r) begin
				t2_cnt_r <= t2_ovf ? t2_reload_r : t2_cnt_r + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// receive pin synchroniser and edge
	// ----------------------------------------------------------------
	logic rx_m1_r;
	logic rx_m2_r;
	logic rx_m3_r;
	logic rx_d_r;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_m1_r <= 1'b1;
			rx_m2_r <= 1'b1;
			rx_m3_r <= 1'b1;
			rx_s_r  <= 1'b1;
			rx_d_r  <= 1'b1;
		end else begin
			rx_m1_r <= rxd_i;
			rx_m2_r <= rx_m1_r;
			rx_m3_r <= rx_m2_r;
			if (rx_m2_r == rx_m3_r) begin
				rx_s_r <= rx_m3_r;
			end
			rx_d_r <= rx_s_r;
		end
	end

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	umb_tx_e    tx_st_r;
	logic [3:0] tx_sub_r;
	logic [3:0] tx_cnt_r;
	logic [8:0] tx_sh_r;
	logic       tx_pend_r;
	logic       tx_line_r;
	logic       tx_bit;
	logic [3:0] tx_last;

	assign tx_bit  = tx_tick && (tx_sub_r == SUB_LAST);
	assign tx_last = nine ? MODE9_LAST : MODE1_LAST;
	assign ti_set  = (tx_st_r == TX_SEND && tx_bit && tx_cnt_r == tx_last)
	              || (tx_st_r == TX_SH0 && mc_tick && tx_cnt_r == BITS8_LAST);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_sub_r <= 4'h0;
		end else if (tx_tick) begin
			tx_sub_r <= tx_sub_r + 4'h1;
		end
	end

	// a write during a frame is kept and sent after it
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_pend_r <= 1'b0;
		end else if (wr_data) begin
			tx_pend_r <= 1'b1;
		end else if (tx_st_r == TX_IDLE && tx_pend_r && (mode0 ? mc_tick : tx_bit)) begin
			tx_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_st_r   <= TX_IDLE;
			tx_cnt_r  <= 4'h0;
			tx_sh_r   <= 9'h1ff;
			tx_line_r <= 1'b1;
		end else begin
			case (tx_st_r)
				TX_IDLE: begin
					if (tx_pend_r && mode0 && mc_tick) begin
						tx_st_r  <= TX_SH0;
						tx_sh_r  <= {1'b1, tx_data_r};
						tx_cnt_r <= 4'h0;
					end else if (tx_pend_r && !mode0 && tx_bit) begin
						tx_st_r   <= TX_SEND;
						tx_line_r <= 1'b0;
						tx_sh_r   <= {nine ? ctrl_r[CTL_TB8] : 1'b1, tx_data_r};
						tx_cnt_r  <= 4'h0;
					end
				end
				TX_SEND: begin
					if (tx_bit) begin
						tx_line_r <= tx_sh_r[0];
						tx_sh_r   <= {1'b1, tx_sh_r[8:1]};
						tx_cnt_r  <= tx_cnt_r + 4'h1;
						if (tx_cnt_r == tx_last) begin
							tx_st_r <= TX_STOP;
						end
					end
				end
				TX_STOP: begin
					if (tx_bit) begin
						tx_st_r <= TX_IDLE;
					end
				end
				TX_SH0: begin
					if (mc_tick) begin
						tx_sh_r  <= {1'b1, tx_sh_r[8:1]};
						tx_cnt_r <= tx_cnt_r + 4'h1;
						if (tx_cnt_r == BITS8_LAST) begin
							tx_st_r <= TX_IDLE;
						end
					end
				end
				default: begin
					tx_st_r <= TX_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// receiver
	// ----------------------------------------------------------------
	umb_rx_e    rx_st_r;
	logic [3:0] rx_sub_r;
	logic [3:0] rx_cnt_r;
	logic [8:0] rx_sh_r;
	logic       rx_sh0_end;

	assign rx_async_end = rx_st_r == RX_DATA && rx_tick && rx_sub_r == SUB_LAST && rx_cnt_r == MODE1_LAST;
	assign rx_sh0_end   = rx_st_r == RX_SH0 && mc_tick && rx_cnt_r == BITS8_LAST;
	// final bit is the stop bit in mode 01 and the ninth bit otherwise
	assign rx_accept = !ctrl_r[CTL_RI] && (rx_sh0_end
	                || (rx_async_end && (!ctrl_r[CTL_MP] || rx_s_r)));

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_buf_r <= RST_REG;
		end else if (rx_accept) begin
			rx_buf_r <= rx_sh_r[8:1];
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_st_r  <= RX_IDLE;
			rx_sub_r <= 4'h0;
			rx_cnt_r <= 4'h0;
			rx_sh_r  <= 9'h000;
		end else begin
			case (rx_st_r)
				RX_IDLE: begin
					if (mode0 && ctrl_r[CTL_REN] && !ctrl_r[CTL_RI] && mc_tick) begin
						rx_st_r  <= RX_SH0;
						rx_cnt_r <= 4'h0;
					end else if (!mode0 && ctrl_r[CTL_REN] && rx_d_r && !rx_s_r) begin
						rx_st_r  <= RX_START;
						rx_sub_r <= 4'h0;
					end
				end
				RX_START: begin
					if (rx_tick) begin
						rx_sub_r <= rx_sub_r + 4'h1;
						if (rx_sub_r == RX_MID) begin
							rx_st_r  <= rx_s_r ? RX_IDLE : RX_DATA;
							rx_sub_r <= 4'h0;
							rx_cnt_r <= 4'h0;
						end
					end
				end
				RX_DATA: begin
					if (rx_tick) begin
						rx_sub_r <= rx_sub_r + 4'h1;
						if (rx_sub_r == SUB_LAST) begin
							rx_sh_r  <= {rx_s_r, rx_sh_r[8:1]};
							rx_cnt_r <= rx_cnt_r + 4'h1;
							if (rx_cnt_r == MODE1_LAST) begin
								rx_st_r <= RX_IDLE;
							end
						end
					end
				end
				RX_SH0: begin
					if (m_cnt_r == M0_HIGH) begin
						rx_sh_r <= {rx_s_r, rx_sh_r[8:1]};
					end
					if (mc_tick) begin
						rx_cnt_r <= rx_cnt_r + 4'h1;
						if (rx_cnt_r == BITS8_LAST) begin
							rx_st_r <= RX_IDLE;
						end
					end
				end
				default: begin
					rx_st_r <= RX_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	logic shift_low;

	assign shift_low = (tx_st_r == TX_SH0 || rx_st_r == RX_SH0) && (m_cnt_r < M0_HIGH);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			txd_o    <= 1'b1;
			rxd_o    <= 1'b1;
			rxd_oe_o <= 1'b0;
		end else begin
			txd_o    <= mode0 ? !shift_low : tx_line_r;
			rxd_o    <= tx_sh_r[0];
			rxd_oe_o <= (tx_st_r == TX_SH0);
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	sequence s_clk_low;
		!txd_o [*6];
	endsequence
	sequence s_clk_high;
		txd_o [*6];
	endsequence

	a_shift_clock_shape: assert property (
		(tx_st_r == TX_SH0 && m_cnt_r == 4'h0 && mode0) |=> s_clk_low ##1 s_clk_high)
		else $error("shift clock not six low then six high");
	a_shift_rx_start: assert property (
		$rose(rx_st_r == RX_SH0) |-> $past(ctrl_r[CTL_REN] && !ctrl_r[CTL_RI]))
		else $error("shift receive started while disabled or flagged");
	a_async_rx_enable: assert property (
		$rose(rx_st_r == RX_START) |-> $past(ctrl_r[CTL_REN]) && !$past(rx_s_r))
		else $error("async receive started without enable or low line");
	a_start_bit_low: assert property (
		$rose(tx_st_r == TX_SEND) && !mode0 |=> !txd_o)
		else $error("frame did not open with a low start bit");
	a_ti_on_stop: assert property (
		$rose(ctrl_r[CTL_TI]) && $past(tx_st_r == TX_SEND) |=> txd_o)
		else $error("transmit flag raised without stop bit on line");
	a_buf_only_accept: assert property (
		$changed(rx_buf_r) |-> $rose(ctrl_r[CTL_RI]) && !$past(ctrl_r[CTL_RI]))
		else $error("receive buffer changed without accepted frame");
	a_mp_ninth_gate: assert property (
		($rose(ctrl_r[CTL_RI]) && ctrl_r[CTL_MP] && !mode0 && $past(rx_st_r == RX_DATA)) |-> ctrl_r[CTL_RB8])
		else $error("multiprocessor frame accepted with ninth bit zero");
	a_write_starts_tx: assert property (
		(wr_data && mode0 && tx_st_r == TX_IDLE) |-> ##[1:13] (tx_st_r == TX_SH0))
		else $error("data write did not start shift transmission");
	a_frac_source: assert property (
		(frac_en_r && !mode2 && !frac_tick_i) |-> !tx_tick && !rx_tick)
		else $error("baud tick without fractional tick while enabled");

endmodule

// *** testbench/tb_top.sv ***
/*
 * Self-checking bench of the serial port: register tasks, frame checks in all four modes and the fixed, fractional and timer-one baud sources.
 * Assumes the design answers reads one cycle later and the remote device model on the serial pins.
 */
`timescale 1ns/10ps
module tb_top;
	import umb_pkg::*;
	logic        clk_i;
	logic        rstn_i;
	umb_req_s    req;
	logic [7:0]  rd_data;
	logic        rxd_drv;
	logic        rxd_oe;
	logic        txd;
	logic        frac_tick;
	logic        frac_on;
	logic        peer_line;
	wire         rxd_pin = rxd_oe ? rxd_drv : peer_line;
	int          n_errors;
	int          n_tests;
	int          cyc;
	int          per;
	logic [7:0]  rv;
	logic [7:0]  got;
	logic [7:0]  ctl;

	umb_uart umb_uart_inst (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req), .rd_data_o(rd_data),
		.rxd_i(rxd_pin), .frac_tick_i(frac_tick), .rxd_o(rxd_drv), .rxd_oe_o(rxd_oe), .txd_o(txd));
	umb_peer umb_peer_inst (.clk_i(clk_i), .txd_i(txd), .line_o(peer_line));

	initial clk_i = 1'b0;
	always #2.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		frac_tick <= frac_on && (cyc % 4 == 0);
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_i);
		req <= '0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_i);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_i);
		req <= '0;
		@(negedge clk_i);
		d = rd_data;
	endtask
	task automatic mode(input logic [7:0] v);
		ctl = v;
		wr(ADDR_CTRL, v);
	endtask
	task automatic tx_case(input logic [7:0] d, input logic nine, input int n, input int p);
		logic [10:0] fb;
		wr(ADDR_DATA, d);
		umb_peer_inst.recv(fb, n, p);
		chk("tx frame", 16'((n == 11) ? {1'b1, nine, d, 1'b0} : {2'b01, d, 1'b0}), 16'(fb));
		rd(ADDR_CTRL, rv);
		chk("tx flag", 16'h1, 16'(rv[CTL_TI]));
		wr(ADDR_CTRL, ctl);
	endtask
	task automatic rx_case(input logic [7:0] d, input logic nine, input int n, input int p, input logic [9:0] exp);
		logic [1:0] f;
		umb_peer_inst.send((n == 11) ? {1'b1, nine, d, 1'b0} : {2'b01, d, 1'b0}, n, p);
		repeat (8) @(posedge clk_i);
		rd(ADDR_CTRL, rv);
		f = {rv[CTL_RI], rv[CTL_RB8]};
		rd(ADDR_DATA, rv);
		chk("rx flag ninth data", 16'(exp), 16'({f, rv}));
	endtask
	task automatic wait_txd(input logic v);
		int t;
		t = 0;
		while (txd !== v && t < 2000) begin
			@(negedge clk_i);
			t++;
		end
	endtask
	// shift mode: peer offers d, sampled value of the data pin at each rising clock
	task automatic m0_run(input logic [7:0] d);
		int t0;
		for (int i = 0; i < 8; i++) begin
			wait_txd(1'b0);
			if (i == 0) t0 = cyc;
			if (i == 1) per = cyc - t0;
			umb_peer_inst.put(d[i]);
			wait_txd(1'b1);
			got[i] = rxd_pin;
		end
		umb_peer_inst.put(1'b1);
		repeat (12) @(posedge clk_i);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		#300000;
		n_errors++;
		stop_test;
	end
	initial begin
		rstn_i = 1'b0;
		req = '0;
		frac_on = 1'b0;
		ctl = 8'h00;
		n_errors = 0;
		n_tests = 0;
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'b1;
		for (int a = 0; a < 8; a++) begin
			rd(3'(a), rv);
			chk("reset value", 16'h0, 16'(rv));
		end
		wr(ADDR_PWR, 8'hFF);
		rd(ADDR_PWR, rv);
		chk("power readback", 16'h80, 16'(rv));
		$display("test registers done");
		mode(8'h00);
		wr(ADDR_DATA, 8'hB4);
		m0_run(~8'hB4);
		chk("shift tx data", 16'hB4, 16'(got));
		chk("shift period", 16'd12, 16'(per));
		rd(ADDR_CTRL, rv);
		chk("shift tx flag", 16'h1, 16'(rv[CTL_TI]));
		mode(8'h10);
		m0_run(8'h6D);
		rd(ADDR_CTRL, rv);
		got = rv;
		rd(ADDR_DATA, rv);
		chk("shift rx", 16'h16D, 16'({got[CTL_RI], rv}));
		$display("test shift mode done");
		wr(ADDR_PWR, 8'h00);
		mode(8'h80);
		tx_case(8'hA5, 1'b0, 11, 64);
		wr(ADDR_PWR, 8'h80);
		mode(8'h98);
		tx_case(8'h5A, 1'b1, 11, 32);
		rx_case(8'h3C, 1'b1, 11, 32, 10'h33C);
		rx_case(8'h55, 1'b0, 11, 32, 10'h33C);
		mode(8'hB8);
		rx_case(8'h66, 1'b0, 11, 32, 10'h03C);
		rx_case(8'h99, 1'b1, 11, 32, 10'h399);
		mode(8'h88);
		rx_case(8'h11, 1'b1, 11, 32, 10'h099);
		$display("test fixed rate done");
		frac_on <= 1'b1;
		wr(ADDR_FRAC, 8'h80);
		wr(ADDR_T2CTL, 8'h30);
		mode(8'h50);
		tx_case(8'hC3, 1'b0, 10, 64);
		rx_case(8'h81, 1'b0, 10, 64, 10'h381);
		$display("test fractional source done");
		wr(ADDR_FRAC, 8'h00);
		frac_on <= 1'b0;
		wr(ADDR_T2CTL, 8'h00);
		wr(ADDR_T1RL, 8'hFF);
		mode(8'h50);
		tx_case(8'h0F, 1'b0, 10, 192);
		rx_case(8'h42, 1'b0, 10, 192, 10'h342);
		mode(8'hD0);
		tx_case(8'hF0, 1'b0, 11, 192);
		rx_case(8'h24, 1'b1, 11, 192, 10'h324);
		$display("test timer source done");
		stop_test;
	end
endmodule

// *** testbench/umb_peer.sv ***
/*
 * Remote serial device: drives frames onto the receive line and decodes frames seen on the transmit line.
 * Assumes bit times are given in core clock cycles and that the receive line has a pull-up.
 */
`timescale 1ns/10ps
module umb_peer (
	input  wire logic clk_i,
	input  wire logic txd_i,
	output logic      line_o
);
	initial line_o = 1'b1;

	// ----------------------------------------------------------------
	// line drive
	// ----------------------------------------------------------------
	task automatic put(input logic b);
		line_o <= b;
	endtask

	// frame out LSB first, then release to the pull-up level
	task automatic send(input logic [10:0] bits, input int n, input int per);
		for (int i = 0; i < n; i++) begin
			line_o <= bits[i];
			repeat (per) @(posedge clk_i);
		end
		line_o <= 1'b1;
	endtask

	// ----------------------------------------------------------------
	// frame decode, sampled mid-bit
	// ----------------------------------------------------------------
	task automatic recv(output logic [10:0] bits, input int n, input int per);
		int t;
		bits = '0;
		t = 0;
		while (txd_i !== 1'b0 && t < 20000) begin
			@(negedge clk_i);
			t++;
		end
		repeat (per / 2) @(negedge clk_i);
		for (int i = 0; i < n; i++) begin
			bits[i] = txd_i;
			repeat (per) @(negedge clk_i);
		end
	endtask
endmodule
